// *** common/eee_tx_lpi_timing_defs.vh ***
// register map, field layout, reset values and timing counts of the eee transmit lpi timer
// Contract
// - after tx fifo empties, wait idle_entry_delay_count microseconds, then start lpi
// - fifo empty with energy_saving_enable clear: no lpi action, delay not run
// - delay expiry starts lpi and sets lpi_entry_irq_flag
// - delays use a 1 us prescaler; up to 1 us extra delay (the gigabit wake-wait counts half-microsecond ticks instead)
// - zero idle-entry delay is legal and starts lpi with no wait
// - fifo becoming non-empty during the delay restarts the delay timer
// - after lpi exit, transmission waits the wake-wait time on top of ipg
// - gigabit or fast wake-wait field chosen from the current link speed
// - fast wake-wait is bits 15:0, microsecond units, reset 0x1e
// - lpi only when enabled, 100/1000 full duplex, both partners support eee
`ifndef EEE_TX_LPI_TIMING_DEFS_VH
`define EEE_TX_LPI_TIMING_DEFS_VH

// register byte offsets
`define OFS_LPI_ENTRY_DELAY 12'h130
`define OFS_LPI_EXIT_WAKE_WAIT 12'h134
`define OFS_MAC_CONTROL 12'h150
`define OFS_INT_STATUS 12'h154
`define OFS_INT_MASK 12'h158
`define OFS_LPI_STATE 12'h15C

// reset values
`define RST_LPI_ENTRY_DELAY 32'h0000_0000
`define RST_WAKE_WAIT_GIG 16'h0021
`define RST_WAKE_WAIT_FAST 16'h001E

// field positions
`define WAKE_GIG_MSB 31
`define WAKE_GIG_LSB 16
`define WAKE_FAST_MSB 15
`define WAKE_FAST_LSB 0
`define CTRL_EEE_EN_BIT 0
`define STS_LPI_ENTRY_BIT 0
`define STS_LPI_EXIT_BIT 1
`define STS_WIDTH 2

// timing: clock period, prescaler units, cycle counts derived from them
`define CLK_PERIOD_NS 10
`define US_UNIT_NS 1000
`define HALF_US_UNIT_NS 500
`define US_CYCLES ((`US_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_US_CYCLES ((`HALF_US_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** design/eee_tx_lpi_timing.v ***
// transmit-side energy efficient ethernet lpi entry delay and wake-wait timer with apb registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "eee_tx_lpi_timing_defs.vh"

module eee_tx_lpi_timing #(
    parameter DELAY_WIDTH = 32,
    parameter WAKE_WIDTH = 16
)
(
    input wire pclk, // 100 MHz system clock
    input wire presetn, // asynchronous reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output wire pready, // apb ready, always high
    output wire pslverr, // apb error on unmapped address
    input wire tx_fifo_empty, // transmit fifo holds no data
    input wire link_speed_gig, // link runs at 1000 Mb/s
    input wire link_speed_fast, // link runs at 100 Mb/s
    input wire link_full_duplex, // link is full duplex
    input wire an_eee_gig, // both partners advertise eee at 1000
    input wire an_eee_fast, // both partners advertise eee at 100
    output reg tx_lpi_request, // lpi request toward the phy
    output reg tx_hold, // blocks frame start while lpi or wake-wait
    output reg irq // level interrupt, unmasked status set
);

    // timer states
    localparam ST_ACTIVE = 2'b00;
    localparam ST_DELAY = 2'b01;
    localparam ST_LPI = 2'b10;
    localparam ST_WAKE = 2'b11;

    // prescaler reload, cut to the counter width on purpose
    localparam integer HALF_US_CYCLES_INT = `HALF_US_CYCLES;
    localparam [7:0] HALF_US_COUNT = HALF_US_CYCLES_INT[7:0];

    reg [DELAY_WIDTH-1:0] idle_entry_delay_count;
    reg [WAKE_WIDTH-1:0] wake_wait_count_gig;
    reg [WAKE_WIDTH-1:0] wake_wait_count_fast;
    reg energy_saving_enable;
    reg [`STS_WIDTH-1:0] int_status;
    reg [`STS_WIDTH-1:0] int_mask;
    reg [1:0] state;
    reg [DELAY_WIDTH-1:0] elapsed;
    reg wake_gig;
    reg [7:0] presc;
    reg half_tick;
    reg us_phase;

    reg [1:0] next_state;
    reg [DELAY_WIDTH-1:0] next_elapsed;
    reg next_wake_gig;
    reg entry_event;
    reg exit_event;
    reg [31:0] read_value;
    reg mapped;

    wire us_tick;
    wire wake_tick;
    wire eligible;
    wire setup_phase;
    wire access_phase;
    wire wr_en;
    wire status_read;
    wire [DELAY_WIDTH-1:0] wake_limit;

    // true on a tick once the count has reached its limit
    function expired;
        input tick;
        input [DELAY_WIDTH-1:0] count;
        input [DELAY_WIDTH-1:0] limit;
        begin
            expired = tick && (count == limit);
        end
    endfunction

    // apb decode; zero wait states keep the slave simple
    assign pready = 1'b1;
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_en = access_phase && pwrite && mapped;
    assign status_read = access_phase && !pwrite && (paddr == `OFS_INT_STATUS);
    assign pslverr = access_phase && !mapped;

    // lpi only allowed when the link can carry it
    assign eligible = energy_saving_enable && link_full_duplex &&
                      ((link_speed_gig && an_eee_gig) || (link_speed_fast && an_eee_fast));

    // free-running half-microsecond prescaler, so the first unit may be partial
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc <= 8'h00;
            half_tick <= 1'b0;
            us_phase <= 1'b0;
        end
        else
        begin
            half_tick <= (presc == HALF_US_COUNT - 8'h01);
            if (presc == HALF_US_COUNT - 8'h01)
            begin
                presc <= 8'h00;
                us_phase <= !us_phase;
            end
            else
            begin
                presc <= presc + 8'h01;
            end
        end
    end

    // whole-microsecond tick is every second half tick
    assign us_tick = half_tick && !us_phase;
    // gigabit counts in halves, fast in whole microseconds
    assign wake_tick = wake_gig ? half_tick : us_tick;
    assign wake_limit = wake_gig ? {{(DELAY_WIDTH-WAKE_WIDTH){1'b0}}, wake_wait_count_gig} :
                                   {{(DELAY_WIDTH-WAKE_WIDTH){1'b0}}, wake_wait_count_fast};

    // lpi timer state machine
    always @*
    begin
        next_state = state;
        next_elapsed = elapsed;
        next_wake_gig = wake_gig;
        entry_event = 1'b0;
        exit_event = 1'b0;
        case (state)
            ST_ACTIVE:
            begin
                // disabled or ineligible link: nothing happens at all
                if (eligible && tx_fifo_empty)
                begin
                    next_elapsed = {DELAY_WIDTH{1'b0}};
                    if (idle_entry_delay_count == {DELAY_WIDTH{1'b0}})
                    begin
                        next_state = ST_LPI;
                        entry_event = 1'b1;
                    end
                    else
                    begin
                        next_state = ST_DELAY;
                    end
                end
            end
            ST_DELAY:
            begin
                if (!eligible)
                begin
                    next_state = ST_ACTIVE;
                end
                else if (!tx_fifo_empty)
                begin
                    // restart: the delay begins again once the fifo drains
                    next_state = ST_ACTIVE;
                end
                else if (expired(us_tick, elapsed, idle_entry_delay_count))
                begin
                    next_state = ST_LPI;
                    entry_event = 1'b1;
                end
                else if (us_tick)
                begin
                    next_elapsed = elapsed + {{(DELAY_WIDTH-1){1'b0}}, 1'b1};
                end
            end
            ST_LPI:
            begin
                // new data or a lost precondition ends lpi; wake-wait still applies
                if (!tx_fifo_empty || !eligible)
                begin
                    next_state = ST_WAKE;
                    next_elapsed = {DELAY_WIDTH{1'b0}};
                    next_wake_gig = link_speed_gig;
                    exit_event = 1'b1;
                end
            end
            ST_WAKE:
            begin
                if ((wake_limit == {DELAY_WIDTH{1'b0}}) || expired(wake_tick, elapsed, wake_limit))
                begin
                    next_state = ST_ACTIVE;
                end
                else if (wake_tick)
                begin
                    next_elapsed = elapsed + {{(DELAY_WIDTH-1){1'b0}}, 1'b1};
                end
            end
            default:
            begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // state, counter and phy-facing outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_ACTIVE;
            elapsed <= {DELAY_WIDTH{1'b0}};
            wake_gig <= 1'b0;
            tx_lpi_request <= 1'b0;
            tx_hold <= 1'b0;
        end
        else
        begin
            state <= next_state;
            elapsed <= next_elapsed;
            wake_gig <= next_wake_gig;
            tx_lpi_request <= (next_state == ST_LPI);
            // hold covers lpi and wake-wait; the mac adds its ipg after release
            tx_hold <= (next_state == ST_LPI) || (next_state == ST_WAKE);
        end
    end

    // read mux and address map check
    always @*
    begin
        read_value = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `OFS_LPI_ENTRY_DELAY:
                read_value = idle_entry_delay_count;
            `OFS_LPI_EXIT_WAKE_WAIT:
                read_value = {wake_wait_count_gig, wake_wait_count_fast};
            `OFS_MAC_CONTROL:
                read_value[`CTRL_EEE_EN_BIT] = energy_saving_enable;
            `OFS_INT_STATUS:
                read_value[`STS_WIDTH-1:0] = int_status;
            `OFS_INT_MASK:
                read_value[`STS_WIDTH-1:0] = int_mask;
            `OFS_LPI_STATE:
                read_value[3:0] = {eligible, wake_gig, state};
            default:
                mapped = 1'b0;
        endcase
    end

    // register writes; counts are trusted to change only while disabled
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_entry_delay_count <= `RST_LPI_ENTRY_DELAY;
            wake_wait_count_gig <= `RST_WAKE_WAIT_GIG;
            wake_wait_count_fast <= `RST_WAKE_WAIT_FAST;
            energy_saving_enable <= 1'b0;
            int_mask <= {`STS_WIDTH{1'b0}};
        end
        else if (wr_en)
        begin
            case (paddr)
                `OFS_LPI_ENTRY_DELAY:
                    idle_entry_delay_count <= pwdata[DELAY_WIDTH-1:0];
                `OFS_LPI_EXIT_WAKE_WAIT:
                begin
                    wake_wait_count_gig <= pwdata[`WAKE_GIG_MSB:`WAKE_GIG_LSB];
                    wake_wait_count_fast <= pwdata[`WAKE_FAST_MSB:`WAKE_FAST_LSB];
                end
                `OFS_MAC_CONTROL:
                    energy_saving_enable <= pwdata[`CTRL_EEE_EN_BIT];
                `OFS_INT_MASK:
                    int_mask <= pwdata[`STS_WIDTH-1:0];
                default:
                    int_mask <= int_mask;
            endcase
        end
    end

    // read data captured in the setup cycle so prdata comes from a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata <= read_value;
        end
    end

    // sticky status, cleared by read of what was returned; a new event wins
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_status <= {`STS_WIDTH{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            int_status <= (int_status & ~(status_read ? prdata[`STS_WIDTH-1:0] : {`STS_WIDTH{1'b0}})) |
                          {exit_event, entry_event};
            irq <= |(next_irq_bits(int_status, prdata[`STS_WIDTH-1:0], status_read,
                                   {exit_event, entry_event}) & int_mask);
        end
    end

    // status value after this cycle, shared by the irq path
    function [`STS_WIDTH-1:0] next_irq_bits;
        input [`STS_WIDTH-1:0] cur;
        input [`STS_WIDTH-1:0] seen;
        input rd;
        input [`STS_WIDTH-1:0] set;
        begin
            next_irq_bits = (cur & ~(rd ? seen : {`STS_WIDTH{1'b0}})) | set;
        end
    endfunction

endmodule // eee_tx_lpi_timing

`default_nettype wire

// *** bench/eee_tx_lpi_timing_props.sv ***
// port checker for the eee transmit lpi timer
`timescale 1ns/1ps
`default_nettype none
module eee_tx_lpi_timing_props (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic [11:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic tx_fifo_empty, // fifo empty
    input wire logic link_speed_gig, // at 1000
    input wire logic link_speed_fast, // at 100
    input wire logic link_full_duplex, // full duplex
    input wire logic an_eee_gig, // eee at 1000
    input wire logic an_eee_fast, // eee at 100
    input wire logic tx_lpi_request, // lpi out
    input wire logic tx_hold // frame start blocked
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // link may use lpi at its current speed
    wire elig = link_full_duplex && (link_speed_gig && an_eee_gig || link_speed_fast && an_eee_fast);
    sequence s_lpi_data;
        tx_lpi_request && !tx_fifo_empty;
    endsequence
    sequence s_wake;
        !tx_lpi_request && tx_hold;
    endsequence
    AST_READY: assert property (pready) else $error("pready low");
    AST_ERR_ACCESS: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    AST_MAPPED: assert property (psel && penable && paddr == 12'h130 |-> !pslverr) else $error("mapped refused");
    AST_ENTRY_COND: assert property ($rose(tx_lpi_request) |-> $past(elig && tx_fifo_empty))
        else $error("lpi entered while not allowed");
    AST_EXIT_DATA: assert property (s_lpi_data |=> s_wake) else $error("no wake on data");
    AST_LPI_HOLDS: assert property (tx_lpi_request |-> tx_hold) else $error("lpi without hold");
    AST_HOLD_END: assert property ($fell(tx_hold) |-> $past(!tx_lpi_request)) else $error("hold ends early");
    // counts below the minimum are never programmed, so wake spans many cycles
    AST_WAKE_MIN: assert property ($fell(tx_lpi_request) |-> tx_hold [*8]) else $error("wake too short");
endmodule // eee_tx_lpi_timing_props
bind eee_tx_lpi_timing eee_tx_lpi_timing_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready,
    .pslverr, .tx_fifo_empty, .link_speed_gig, .link_speed_fast, .link_full_duplex, .an_eee_gig, .an_eee_fast,
    .tx_lpi_request, .tx_hold);
`default_nettype wire

// *** bench/phy_tx_model.sv ***
// far-side model: transmit fifo level and frame sender toward the phy
`timescale 1ns/1ps
`default_nettype none
module phy_tx_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic push, // queue one frame
    input wire logic tx_hold, // mac blocks frame start
    output wire logic tx_fifo_empty, // nothing queued or sending
    output var logic frame_start // pulse per frame
);
    logic [7:0] pend;
    logic [3:0] busy;
    // a frame starts only while the mac does not hold
    wire go = busy == 4'h0 && pend != 8'h00 && !tx_hold;
    assign tx_fifo_empty = pend == 8'h00 && busy == 4'h0;
    // frames leave one at a time, eight cycles each
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend <= 8'h00;
            busy <= 4'h0;
            frame_start <= 1'b0;
        end
        else
        begin
            pend <= pend + {7'h00, push} - {7'h00, go};
            busy <= go ? 4'h8 : busy - {3'h0, busy != 4'h0};
            frame_start <= go;
        end
    end
endmodule // phy_tx_model
`default_nettype wire

// *** bench/eee_tx_lpi_timing_test.sv ***
// self-checking bench for the eee transmit lpi timer
`timescale 1ns/1ps
`default_nettype none
`include "eee_tx_lpi_timing_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module eee_tx_lpi_timing_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, push = 1'b0, err;
    logic link_speed_gig = 1'b0, link_speed_fast = 1'b1, link_full_duplex = 1'b0, an_eee_gig = 1'b1;
    logic an_eee_fast = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    wire [31:0] prdata;
    wire pready, pslverr, tx_fifo_empty, tx_lpi_request, tx_hold, irq, frame_start;
    int err_count = 0, num_checks = 0, n;
    localparam logic [31:0] WK = 32'h0021_001E;
    eee_tx_lpi_timing DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_fifo_empty, .link_speed_gig, .link_speed_fast, .link_full_duplex, .an_eee_gig,
        .an_eee_fast, .tx_lpi_request, .tx_hold, .irq);
    phy_tx_model u_phy (.pclk, .presetn, .push, .tx_hold, .tx_fifo_empty, .frame_start);
    initial forever #5 pclk = ~pclk;
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never reassigns psel in this step
        @(posedge pclk);
    endtask
    // counts are changed only with energy saving off
    task automatic setup(input logic [31:0] dly, input logic en);
        apb(1'b1, `OFS_MAC_CONTROL, 32'h0000_0000);
        apb(1'b1, `OFS_LPI_ENTRY_DELAY, dly);
        apb(1'b1, `OFS_LPI_EXIT_WAKE_WAIT, WK);
        apb(1'b1, `OFS_MAC_CONTROL, {31'h0000_0000, en});
    endtask
    // bounded wait on request, frame start, fifo empty or hold
    task automatic wt(input int k, input logic v, input int lim);
        n = 0;
        while ((k == 0 ? tx_lpi_request : k == 1 ? frame_start : k == 2 ? tx_fifo_empty : tx_hold) !== v
               && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic send;
        push <= 1'b1;
        @(posedge pclk);
        push <= 1'b0;
    endtask
    task automatic t_regs;
        apb(1'b0, `OFS_LPI_ENTRY_DELAY, 32'h0000_0000);
        `CHK(rd, `RST_LPI_ENTRY_DELAY)
        apb(1'b0, `OFS_LPI_EXIT_WAKE_WAIT, 32'h0000_0000);
        `CHK(rd, 32'h0021_001E)
        apb(1'b0, 12'h200, 32'h0000_0000);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
    endtask
    // disabled, then half duplex, then eligible with zero delay
    task automatic t_entry;
        setup(32'h0000_0000, 1'b0);
        link_full_duplex <= 1'b1;
        wt(0, 1'b1, 400);
        `CHK(tx_lpi_request, 1'b0)
        // timer must stay in the active state, not run the delay
        apb(1'b0, `OFS_LPI_STATE, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        link_full_duplex <= 1'b0;
        setup(32'h0000_0000, 1'b1);
        wt(0, 1'b1, 400);
        `CHK(tx_lpi_request, 1'b0)
        // full duplex but partner lacks eee at this speed
        link_full_duplex <= 1'b1;
        an_eee_fast <= 1'b0;
        wt(0, 1'b1, 400);
        `CHK(tx_lpi_request, 1'b0)
        an_eee_fast <= 1'b1;
        wt(0, 1'b1, 400);
        `CHK(n < 4, 1'b1)
    endtask
    task automatic t_irq;
        `CHK(irq, 1'b0)
        apb(1'b1, `OFS_INT_MASK, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
        `CHK(rd[0], 1'b1)
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        // the read must have cleared what it returned
        apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
        `CHK(rd[1:0], 2'b00)
    endtask
    // data ends lpi; frame waits the wake time of the current speed
    task automatic t_wake(input int lo, input int hi);
        send();
        wt(0, 1'b0, 20);
        `CHK(tx_hold, 1'b1)
        wt(1, 1'b1, 4000);
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask
    // gigabit entry after a delay, and restart when data arrives meanwhile
    task automatic t_delay;
        wt(2, 1'b1, 50);
        link_speed_gig <= 1'b1;
        link_speed_fast <= 1'b0;
        setup(32'h0000_0002, 1'b1);
        // disabling inside lpi runs a gigabit wake-wait before the delay can start
        wt(3, 1'b0, 2000);
        wt(0, 1'b1, 400);
        `CHK(n >= 202 && n <= 301, 1'b1)
        t_wake(1652, 1701);
        wt(2, 1'b1, 50);
        repeat (150) @(posedge pclk);
        `CHK(tx_lpi_request, 1'b0)
        send();
        wt(2, 1'b0, 10);
        wt(2, 1'b1, 50);
        wt(0, 1'b1, 400);
        `CHK(n >= 202 && n <= 301, 1'b1)
        // unmasked entry flag drives the interrupt
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #200_000;
        err_count++;
        finish_test();
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_entry();
        t_irq();
        t_wake(3002, 3101);
        t_delay();
        finish_test();
    end
endmodule // eee_tx_lpi_timing_test
`default_nettype wire
